// >>> hdl/ssr_status.sv
// status byte, standard event and tester status groups with service request
// assumes command and bus pulses are synchronous to clk and last one cycle
//
// Functional notes
// - status byte readable by query or poll
// - bit 7 shows stored self-test reports
// - bit 6 is request/master summary
// - bit 5 is standard event summary
// - bit 4 shows response data waiting
// - bits 3 and 2 read zero
// - bit 1 is test-function group summary
// - bit 0 is hardware group summary
// - master summary ORs enabled status byte bits
// - master bit not enableable; enable register read/write
// - rising master summary raises service request
// - poll or query acknowledges, request drops
// - master summary persists while cause persists
// - standard event bits 7, 6 read zero
// - bits 5,4,3: syntax, execution, correction
// - bit 2: query error
// - bit 0 set by operation-complete command
// - event summary ORs enabled events; enable read/write
// - condition registers mirror state, read-only
// - falling filter sets event on 1-to-0
// - rising filter sets event on 0-to-1; readable
// - event bits sticky; both groups identical
// - read, clear-status, device clear, reset clear
// - group summary ORs enabled events; mask read/write
`timescale 1ns/10ps
`default_nettype none
module ssr_status #(
    parameter int GRP_W = 8  // condition bits per tester group
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // parser command port
    input wire logic cmd_valid,
    input wire ssr_pkg::ssr_cmd_s cmd,
    output ssr_pkg::ssr_rsp_s rsp,
    // instrument bus events
    input wire logic serial_poll,
    input wire logic device_clear,
    output ssr_pkg::ssr_rsp_s poll_rsp,
    output logic service_request,
    // tester state
    input wire ssr_pkg::ssr_evt_s evt,
    input wire logic self_test_pending,
    input wire logic msg_available,
    input wire logic [GRP_W-1:0] hw_cond,
    input wire logic [GRP_W-1:0] tf_cond
);
    import ssr_pkg::*;

    // zero-extend a group value to a response byte
    function automatic logic [SSR_DW-1:0] widen(input logic [GRP_W-1:0] v);
        logic [SSR_DW-1:0] r;
        r = '0;
        r[GRP_W-1:0] = v;
        return r;
    endfunction

    // true when any enabled bit is set
    function automatic logic any_on(input logic [SSR_DW-1:0] v,
                                    input logic [SSR_DW-1:0] m);
        return |(v & m);
    endfunction

    // standard event bits that exist; the rest read zero
    // bits 7, 6 and 1 are never stored, so no stray set can show up
    localparam logic [SSR_DW-1:0] ESR_USED = 8'h3d;
    // master summary bit can never be enabled
    localparam logic [SSR_DW-1:0] SRE_MASK = 8'hbf;

    logic [SSR_DW-1:0] service_request_enable;  // service-request enable
    logic [SSR_DW-1:0] standard_event_status;  // standard event status
    logic [SSR_DW-1:0] standard_event_enable;  // standard event enable
    logic [GRP_W-1:0] cond [SSR_NGRP];  // live condition
    logic [GRP_W-1:0] prev [SSR_NGRP];  // condition one cycle ago
    logic [GRP_W-1:0] fall [SSR_NGRP];  // falling filter
    logic [GRP_W-1:0] rise [SSR_NGRP];  // rising filter
    logic [GRP_W-1:0] ev [SSR_NGRP];  // sticky events
    logic [GRP_W-1:0] en [SSR_NGRP];  // event enable
    logic [GRP_W-1:0] ev_set [SSR_NGRP];  // filtered transitions
    logic [SSR_NGRP-1:0] ev_clr;  // per-group clear this cycle
    logic [SSR_NGRP-1:0] grp_sum;  // per-group summary
    logic primed;  // prev holds a real sample
    logic esb;  // standard event summary
    logic mss;  // master summary
    logic mss_q;  // master summary one cycle ago
    logic ack;  // request acknowledged this cycle
    logic [SSR_DW-1:0] stb;  // assembled status byte
    logic [SSR_DW-1:0] esr_set;  // standard events this cycle
    logic clr_all;  // clear-status or device clear
    logic [SSR_DW-1:0] next_rdata;  // query answer

    assign cond[GRP_HW] = hw_cond;
    assign cond[GRP_TF] = tf_cond;
    // clear-status empties events only; enables and filters are kept
    assign clr_all = device_clear || (cmd_valid && cmd.op == SSR_CLS);
    // both acknowledgements count the same way
    assign ack = serial_poll || (cmd_valid && cmd.op == SSR_STB_Q);

    // one copy of the group logic per tester group
    for (genvar g = 0; g < SSR_NGRP; g++) begin : grp
        // transitions that pass the filter
        assign ev_set[g] = primed ?
            ((cond[g] & ~prev[g] & rise[g]) |
             (~cond[g] & prev[g] & fall[g])) : '0;
        // read of this group's events, or a global clear
        assign ev_clr[g] = clr_all || (cmd_valid && cmd.op == SSR_EVT_Q
                                       && int'(cmd.grp) == g);
        assign grp_sum[g] = |(ev[g] & en[g]);

        // previous condition for edge detection
        // runs every cycle, so a read never hides a transition
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                prev[g] <= '0;
            end else begin
                prev[g] <= cond[g];
            end
        end

        // filter and enable masks, written only by their commands
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                fall[g] <= '0;
                rise[g] <= '0;
                en[g] <= '0;
            end else if (cmd_valid && int'(cmd.grp) == g) begin
                case (cmd.op)
                    SSR_FALL_W: fall[g] <= cmd.data[GRP_W-1:0];
                    SSR_RISE_W: rise[g] <= cmd.data[GRP_W-1:0];
                    SSR_EN_W: en[g] <= cmd.data[GRP_W-1:0];
                    default: begin
                    end
                endcase
            end
        end

        // sticky events: new transitions win over a clear in the same cycle
        // a clear that won would lose an event that no later read could see
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                ev[g] <= '0;
            end else if (ev_clr[g]) begin
                ev[g] <= ev_set[g];
            end else begin
                ev[g] <= ev[g] | ev_set[g];
            end
        end
    end

    // first cycle after reset has no valid previous sample
    // without it a condition already high at reset would look like a rise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            primed <= 1'b0;
        end else begin
            primed <= 1'b1;
        end
    end

    // standard events arriving this cycle
    always_comb begin
        esr_set = '0;
        esr_set[ESR_CME] = evt.syntax_err;
        esr_set[ESR_EXE] = evt.exec_err;
        esr_set[ESR_ATC] = evt.auto_correction_event;
        esr_set[ESR_QYE] = evt.query_err;
        esr_set[ESR_OPC] = cmd_valid && cmd.op == SSR_OPC;
    end

    // standard event register; unused bits never load
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            standard_event_status <= SSR_RST_BYTE;
        end else if (clr_all || (cmd_valid && cmd.op == SSR_ESR_Q)) begin
            standard_event_status <= esr_set & ESR_USED;
        end else begin
            standard_event_status <= (standard_event_status | esr_set) & ESR_USED;
        end
    end

    // enable registers; the master bit of the request enable is dropped
    // dropping it at write time keeps the readback honest as well
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            service_request_enable <= SSR_RST_BYTE;
            standard_event_enable <= SSR_RST_BYTE;
        end else if (cmd_valid) begin
            case (cmd.op)
                SSR_SRE_W: service_request_enable <= cmd.data & SRE_MASK;
                SSR_ESE_W: standard_event_enable <= cmd.data;
                default: begin
                end
            endcase
        end
    end

    // summaries straight from current contents, no added latency
    assign esb = any_on(standard_event_status, standard_event_enable);
    always_comb begin
        stb = '0;
        stb[STB_SELF] = self_test_pending;
        stb[STB_ESB] = esb;
        stb[STB_MAV] = msg_available;
        stb[STB_TFS] = grp_sum[GRP_TF];
        stb[STB_HWS] = grp_sum[GRP_HW];
        // mss is taken before bit 6 is placed, so it never feeds itself
        mss = any_on(stb, service_request_enable);
        stb[STB_MSS] = mss;
    end

    // master summary history for edge detection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mss_q <= 1'b0;
        end else begin
            mss_q <= mss;
        end
    end

    // service request: a new rise beats an acknowledge in the same cycle
    // a flop, so the bus sees a clean level with no combinational glitch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            service_request <= 1'b0;
        end else if (mss && !mss_q) begin
            service_request <= 1'b1;
        end else if (ack) begin
            service_request <= 1'b0;
        end
    end

    // answer byte for each query
    // binary only; decimal text for condition queries is done downstream
    always_comb begin
        next_rdata = '0;
        case (cmd.op)
            SSR_STB_Q: next_rdata = stb;
            SSR_SRE_Q: next_rdata = service_request_enable;
            SSR_ESR_Q: next_rdata = standard_event_status;
            SSR_ESE_Q: next_rdata = standard_event_enable;
            SSR_COND_Q: next_rdata = widen(cond[cmd.grp]);
            SSR_FALL_Q: next_rdata = widen(fall[cmd.grp]);
            SSR_RISE_Q: next_rdata = widen(rise[cmd.grp]);
            SSR_EVT_Q: next_rdata = widen(ev[cmd.grp]);
            SSR_EN_Q: next_rdata = widen(en[cmd.grp]);
            default: next_rdata = '0;
        endcase
    end

    // query answer, registered; writes and clears give no answer
    // data is zero between answers, so a stale byte is never left showing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp <= '0;
        end else begin
            rsp.valid <= cmd_valid && cmd.op inside {SSR_STB_Q, SSR_SRE_Q,
                SSR_ESR_Q, SSR_ESE_Q, SSR_COND_Q, SSR_FALL_Q, SSR_RISE_Q,
                SSR_EVT_Q, SSR_EN_Q};
            rsp.data <= cmd_valid ? next_rdata : '0;
        end
    end

    // serial poll answer, registered
    // the byte of the poll cycle itself, master bit included
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            poll_rsp <= '0;
        end else begin
            poll_rsp.valid <= serial_poll;
            poll_rsp.data <= serial_poll ? stb : '0;
        end
    end

    // checks of the guarded behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // polled byte: each bit against what fed it one cycle earlier
    poll_byte_a: assert property (serial_poll |=>
        poll_rsp.valid && poll_rsp.data == $past(stb))
        else $error("poll answer does not match status byte");
    rsp_idle_a: assert property (!rsp.valid |-> rsp.data == '0)
        else $error("query answer data without valid");
    stb_self_a: assert property (poll_rsp.valid |->
        poll_rsp.data[STB_SELF] == $past(self_test_pending))
        else $error("self-test bit wrong in polled byte");
    unused_stb_a: assert property (poll_rsp.data[3:2] == 2'b00)
        else $error("unused status bits set");
    stb_esb_a: assert property (poll_rsp.valid |->
        poll_rsp.data[STB_ESB] == |($past(standard_event_status & standard_event_enable)))
        else $error("event summary wrong in polled byte");
    stb_mav_a: assert property (poll_rsp.valid |->
        poll_rsp.data[STB_MAV] == $past(msg_available))
        else $error("message bit wrong in polled byte");
    stb_groups_a: assert property (poll_rsp.valid |->
        poll_rsp.data[STB_TFS] == |($past(ev[GRP_TF] & en[GRP_TF])) &&
        poll_rsp.data[STB_HWS] == |($past(ev[GRP_HW] & en[GRP_HW])))
        else $error("group summary wrong in polled byte");
    mss_sum_a: assert property (poll_rsp.valid |->
        poll_rsp.data[STB_MSS] == |(poll_rsp.data & $past(service_request_enable)))
        else $error("master summary wrong in polled byte");
    sre_bit_a: assert property (service_request_enable[STB_MSS] == 1'b0)
        else $error("master summary bit became enableable");

    // service request: raised on a rise, held, dropped on acknowledge
    srq_rise_a: assert property ($rose(mss) |=> service_request)
        else $error("service request not raised");
    srq_hold_a: assert property (service_request && !ack
        |=> service_request)
        else $error("service request dropped without acknowledge");
    srq_ack_a: assert property (ack && mss_q
        |=> !service_request)
        else $error("service request not dropped on acknowledge");
    mss_hold_a: assert property (ack && mss
        ##1 $stable(stb & service_request_enable) |-> stb[STB_MSS])
        else $error("master summary lost while cause holds");
    srq_fast_a: assert property (grp_sum[GRP_HW] && service_request_enable[STB_HWS]
        && !mss_q |=> service_request)
        else $error("enabled group event slow to reach request");

    // standard events: each source lands on its bit, unused bits stay zero
    esr_unused_a: assert property (standard_event_status[7:6] == 2'b00 && !standard_event_status[1])
        else $error("unused standard event bits set");
    esr_cme_a: assert property (evt.syntax_err |=> standard_event_status[ESR_CME])
        else $error("syntax error not recorded");
    esr_exe_a: assert property (evt.exec_err |=> standard_event_status[ESR_EXE])
        else $error("execution error not recorded");
    esr_atc_a: assert property (evt.auto_correction_event
        |=> standard_event_status[ESR_ATC])
        else $error("auto correction not recorded");
    esr_qye_a: assert property (evt.query_err |=> standard_event_status[ESR_QYE])
        else $error("query error not recorded");
    esr_opc_a: assert property (cmd_valid && cmd.op == SSR_OPC
        |=> standard_event_status[ESR_OPC])
        else $error("operation complete not recorded");
    ese_write_a: assert property (cmd_valid
        && cmd.op == SSR_ESE_W |=> standard_event_enable == $past(cmd.data))
        else $error("event enable write lost");

    // tester groups: live mirror, filtered transitions, sticky, cleared
    cond_query_a: assert property (cmd_valid && !cmd.grp
        && cmd.op == SSR_COND_Q |=> rsp.data == $past(widen(hw_cond)))
        else $error("condition query does not mirror live state");
    hw_rise_a: assert property (primed &&
        |(hw_cond & ~prev[GRP_HW] & rise[GRP_HW])
        |=> |(ev[GRP_HW] & $past(hw_cond & rise[GRP_HW])))
        else $error("rising transition not recorded");
    tf_fall_a: assert property (primed &&
        |(~tf_cond & prev[GRP_TF] & fall[GRP_TF])
        |=> |(ev[GRP_TF] & $past(~tf_cond & fall[GRP_TF])))
        else $error("falling transition not recorded");
    hw_sticky_a: assert property (!ev_clr[GRP_HW] |=>
        (ev[GRP_HW] & $past(ev[GRP_HW])) == $past(ev[GRP_HW]))
        else $error("sticky event bit dropped");
    tf_sticky_a: assert property (!ev_clr[GRP_TF] |=>
        (ev[GRP_TF] & $past(ev[GRP_TF])) == $past(ev[GRP_TF]))
        else $error("test-function sticky event bit dropped");
    tf_clear_a: assert property (ev_clr[GRP_TF]
        && ev_set[GRP_TF] == '0 |=> ev[GRP_TF] == '0)
        else $error("test-function events not cleared");
    hw_clear_a: assert property (device_clear
        && ev_set[GRP_HW] == '0 |=> ev[GRP_HW] == '0)
        else $error("hardware events not cleared on device clear");
    tf_enable_a: assert property (cmd_valid && cmd.grp
        && cmd.op == SSR_EN_W |=> en[GRP_TF] == $past(cmd.data[GRP_W-1:0]))
        else $error("test-function enable write lost");
endmodule
`default_nettype wire

// >>> hdl/ssr_pkg.sv
// status reporting package: command codes, carriers, bit positions
// assumes one 8-bit command/response path from the message parser
package ssr_pkg;
    localparam int SSR_DW = 8;  // every register and response is a byte
    localparam int SSR_NGRP = 2;  // hardware and test-function groups
    // status byte bit positions
    localparam int STB_SELF = 7;
    localparam int STB_MSS = 6;
    localparam int STB_ESB = 5;
    localparam int STB_MAV = 4;
    localparam int STB_TFS = 1;
    localparam int STB_HWS = 0;
    // standard event bit positions
    localparam int ESR_CME = 5;
    localparam int ESR_EXE = 4;
    localparam int ESR_ATC = 3;
    localparam int ESR_QYE = 2;
    localparam int ESR_OPC = 0;
    // group index
    localparam int GRP_HW = 0;
    localparam int GRP_TF = 1;
    // reset values
    localparam logic [SSR_DW-1:0] SSR_RST_BYTE = 8'h00;
    // command codes of the parser-facing port
    typedef enum logic [3:0] {
        SSR_STB_Q = 4'h0,  // status byte query, acknowledges request
        SSR_SRE_W = 4'h1,  // service-request enable write
        SSR_SRE_Q = 4'h2,  // service-request enable read
        SSR_ESR_Q = 4'h3,  // standard event read, clears it
        SSR_ESE_W = 4'h4,  // standard event enable write
        SSR_ESE_Q = 4'h5,  // standard event enable read
        SSR_CLS = 4'h6,  // clear status
        SSR_OPC = 4'h7,  // operation complete
        SSR_COND_Q = 4'h8,  // condition_register_query
        SSR_FALL_W = 4'h9,  // falling_filter_write
        SSR_FALL_Q = 4'ha,  // falling filter read
        SSR_RISE_W = 4'hb,  // rising_filter_write
        SSR_RISE_Q = 4'hc,  // rising filter read
        SSR_EVT_Q = 4'hd,  // event_register_query, clears it
        SSR_EN_W = 4'he,  // event_enable_write
        SSR_EN_Q = 4'hf  // event enable read
    } ssr_op_e;
    // one command from the parser
    typedef struct packed {
        ssr_op_e op;  // what to do
        logic grp;  // group for group commands
        logic [SSR_DW-1:0] data;  // write value
    } ssr_cmd_s;
    // one answer byte
    typedef struct packed {
        logic valid;  // one-cycle strobe
        logic [SSR_DW-1:0] data;  // binary value; text formatting is downstream
    } ssr_rsp_s;
    // command-side error and sync events, all one-cycle pulses
    typedef struct packed {
        logic syntax_err;  // command syntax error
        logic exec_err;  // execution error
        logic auto_correction_event;  // tester state was corrected
        logic query_err;  // unrequested read or lost query data
    } ssr_evt_s;
endpackage

// >>> sim/ssr_ctrl_model.sv
// bus controller model: answers a service request with a serial poll
// assumes the request is a level from a flop and the poll a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module ssr_ctrl_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bench control: polling on/off and reaction delay in cycles
    input wire logic enable,
    input wire logic [3:0] wait_cycles,
    // bus lines
    input wire logic service_request,
    output logic serial_poll
);
    initial serial_poll = 1'b0;
    // sample mid-cycle so the flop output has settled, then poll
    // after the chosen delay; prompt and slow controllers both occur
    always begin
        @(negedge clk);
        if (rst_b === 1'b1 && enable === 1'b1 &&
            service_request === 1'b1) begin
            repeat (wait_cycles) @(posedge clk);
            @(posedge clk);
            #1 serial_poll = 1'b1;
            @(posedge clk);
            #1 serial_poll = 1'b0;
            // give the request time to drop before looking again
            repeat (2) @(posedge clk);
        end
    end
endmodule
`default_nettype wire

// >>> sim/status_reporting_srq_logic_bench.sv
// self-checking bench for the status reporting and service request block
// assumes ssr_pkg is compiled first and the controller model is present
`timescale 1ns/10ps
`default_nettype none
module status_reporting_srq_logic_bench;
    import ssr_pkg::*;
    logic clk, rst_b, cmd_valid, device_clear, serial_poll, service_request;
    logic poll_en, self_test_pending, msg_available;
    logic [3:0] poll_wait; // controller reaction delay
    logic [7:0] hw_cond, tf_cond, v;
    ssr_cmd_s cmd;
    ssr_rsp_s rsp, poll_rsp;
    ssr_evt_s evt;
    logic [7:0] rsp_q[$]; // expected query answers, oldest first
    logic [7:0] poll_q[$]; // expected poll answers
    int mismatches, samples_checked, cycles, seed, g;
    ssr_op_e wop;

    ssr_status u_ssr_status (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd(cmd), .rsp(rsp), .serial_poll(serial_poll),
        .device_clear(device_clear), .poll_rsp(poll_rsp),
        .service_request(service_request), .evt(evt),
        .self_test_pending(self_test_pending), .msg_available(msg_available),
        .hw_cond(hw_cond), .tf_cond(tf_cond));
    ssr_ctrl_model u_ssr_ctrl_model (.clk(clk), .rst_b(rst_b),
        .enable(poll_en), .wait_cycles(poll_wait),
        .service_request(service_request), .serial_poll(serial_poll));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("mismatches=%0d samples_checked=%0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one command, held until the next edge takes it
    task automatic send(input ssr_op_e op, input logic grp,
                        input logic [7:0] d);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd = '{op: op, grp: grp, data: d};
    endtask

    // a query, with its expected answer noted
    task automatic ask(input ssr_op_e op, input logic grp,
                       input logic [7:0] e);
        send(op, grp, 8'h00);
        rsp_q.push_back(e);
    endtask

    // drop all strobes, then let n edges pass
    task automatic idle(input int n);
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        evt = '0;
        device_clear = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic set_cond(input logic grp, input logic [7:0] val);
        @(posedge clk);
        #1;
        if (grp) tf_cond = val;
        else hw_cond = val;
    endtask

    // answers are one-cycle strobes, so look once per cycle mid-period
    always @(negedge clk) begin
        if (rsp.valid === 1'b1) begin
            if (rsp_q.size() == 0) check(rsp.data, 8'hxx);
            else check(rsp.data, rsp_q.pop_front());
        end
        if (poll_rsp.valid === 1'b1) begin
            if (poll_q.size() == 0) check(poll_rsp.data, 8'hxx);
            else check(poll_rsp.data, poll_q.pop_front());
        end
    end

    // hang guard, well above the fewer than two hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        seed = 39072;
        rst_b = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        device_clear = 1'b0;
        evt = '0;
        poll_en = 1'b0;
        poll_wait = 4'h0;
        self_test_pending = 1'b0;
        msg_available = 1'b0;
        hw_cond = 8'h00;
        tf_cond = 8'h00;
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        // conditions read back live; filters are still clear here
        for (g = 0; g < 2; g++) begin
            v = 8'($random(seed));
            set_cond(1'(g), v);
            ask(SSR_COND_Q, 1'(g), v);
            idle(1);
            set_cond(1'(g), 8'h00);
        end
        // enable and filter registers: write then read back
        v = 8'($random(seed));
        send(SSR_SRE_W, 1'b0, v);
        ask(SSR_SRE_Q, 1'b0, v & 8'hbf);
        v = 8'($random(seed));
        send(SSR_ESE_W, 1'b0, v);
        ask(SSR_ESE_Q, 1'b0, v);
        for (g = 0; g < 6; g++) begin
            wop = (g % 3 == 0) ? SSR_FALL_W :
                  (g % 3 == 1) ? SSR_RISE_W : SSR_EN_W;
            v = 8'($random(seed));
            send(wop, 1'(g / 3), v);
            ask(ssr_op_e'(wop + 4'h1), 1'(g / 3), v);
        end
        send(SSR_SRE_W, 1'b0, 8'h00);
        send(SSR_ESE_W, 1'b0, 8'h00);
        // transition filter and sticky events, both groups alike
        for (g = 0; g < 2; g++) begin
            send(SSR_RISE_W, 1'(g), 8'h05);
            send(SSR_FALL_W, 1'(g), 8'h04);
            send(SSR_EN_W, 1'(g), 8'h00);
            idle(1);
            set_cond(1'(g), 8'h07);
            idle(2);
            set_cond(1'(g), 8'h02);
            idle(2);
            ask(SSR_EVT_Q, 1'(g), 8'h05);
            ask(SSR_EVT_Q, 1'(g), 8'h00);
            idle(1);
            set_cond(1'(g), 8'h00);
            idle(2);
        end
        // group summary to service request, acknowledged by a poll
        for (g = 0; g < 2; g++) begin
            send(SSR_EN_W, 1'(g), 8'h01);
            send(SSR_SRE_W, 1'b0, 8'h01 << g);
            poll_wait = (g == 0) ? 4'h0 : 4'h6;
            poll_en = 1'b1;
            poll_q.push_back(8'h40 | (8'h01 << g));
            set_cond(1'(g), 8'h01);
            idle(2);
            #1 check({7'h00, service_request}, 8'h01);
            repeat (14) @(posedge clk);
            #1 check({7'h00, service_request}, 8'h00);
            poll_en = 1'b0;
            ask(SSR_STB_Q, 1'b0, 8'h40 | (8'h01 << g));
            ask(SSR_EVT_Q, 1'(g), 8'h01);
            idle(1);
            ask(SSR_STB_Q, 1'b0, 8'h00);
            idle(1);
            set_cond(1'(g), 8'h00);
        end
        send(SSR_SRE_W, 1'b0, 8'h00);
        // each standard event source lands on its own bit
        for (g = 0; g < 4; g++) begin
            idle(1);
            evt = ssr_evt_s'(4'b1000 >> g);
            idle(1);
            ask(SSR_ESR_Q, 1'b0, 8'h20 >> g);
        end
        send(SSR_OPC, 1'b0, 8'h00);
        idle(1);
        ask(SSR_ESR_Q, 1'b0, 8'h01);
        // event summary plus the level bits of the status byte
        send(SSR_ESE_W, 1'b0, 8'h20);
        evt = ssr_evt_s'(4'b1000);
        self_test_pending = 1'b1;
        msg_available = 1'b1;
        idle(1);
        ask(SSR_STB_Q, 1'b0, 8'hb0);
        idle(1);
        device_clear = 1'b1;
        idle(1);
        ask(SSR_ESR_Q, 1'b0, 8'h00);
        idle(1);
        evt = ssr_evt_s'(4'b0100);
        idle(0);
        send(SSR_CLS, 1'b0, 8'h00);
        ask(SSR_ESR_Q, 1'b0, 8'h00);
        idle(4);
        check(8'(rsp_q.size() + poll_q.size()), 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
